/* File: inc/irq_pkg.sv */
// constants, layouts and carriers of the prioritized vector interrupt unit
`default_nettype none
package irq_pkg;
    // sources, by bit position in the enable and priority registers
    localparam int NUM_SRC = 7;
    localparam int SRC_EXT0 = 0;
    localparam int SRC_TIMER0 = 1;
    localparam int SRC_EXT1 = 2;
    localparam int SRC_TIMER1 = 3;
    localparam int SRC_SERIAL = 4;
    localparam int SRC_TIMER2 = 5;
    localparam int SRC_COUNTER_ARRAY = 6;
    localparam int GLOBAL_EN_BIT = 7;
    localparam int NUM_LEVELS = 4;
    localparam int CA_MODULES = 5;

    // polling sequence within one level, first entry polled first
    localparam int POLL_ORDER [0:NUM_SRC-1] = '{
        SRC_EXT0, SRC_TIMER0, SRC_EXT1, SRC_TIMER1,
        SRC_COUNTER_ARRAY, SRC_SERIAL, SRC_TIMER2};

    // vector addresses, indexed by bit position
    localparam logic [15:0] RESET_VECTOR = 16'h0000;
    localparam logic [15:0] SRC_VECTOR [0:NUM_SRC-1] = '{
        16'h0003, 16'h000b, 16'h0013, 16'h001b,
        16'h0023, 16'h002b, 16'h0033};

    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_ENABLE = 8'ha8;
    localparam logic [7:0] IDX_PRIO_HIGH = 8'hb7;
    localparam logic [7:0] IDX_PRIO_LOW = 8'hb8;
    localparam logic [7:0] IDX_BIT_OP = 8'hc0;
    localparam logic [7:0] IDX_STATUS = 8'hc1;
    localparam int ADDR_W = 10;

    // reset values; bit 7 of the priority registers is not stored
    localparam logic [7:0] ENABLE_RESET = 8'h00;
    localparam logic [6:0] PRIO_RESET = 7'h00;

    // bit operation word: bit number, target, value
    localparam int BITOP_NUM_LSB = 0;
    localparam int BITOP_TGT_LSB = 3;
    localparam int BITOP_VAL_BIT = 7;
    localparam logic [1:0] TGT_ENABLE = 2'h0;
    localparam logic [1:0] TGT_PRIO_LOW = 2'h1;

    // status layout: in-service levels, presented level, pending sources
    localparam int STAT_ISV_LSB = 0;
    localparam int STAT_LVL_LSB = 4;
    localparam int STAT_REQ_BIT = 6;
    localparam int STAT_PEND_LSB = 8;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // raw request flags from the peripherals
    typedef struct packed {
        logic ext0_request_flag;
        logic ext1_request_flag;
        logic timer0_overflow_flag;
        logic timer1_overflow_flag;
        logic timer2_overflow_flag;
        logic timer2_external_flag;
        logic serial_receive_flag;
        logic serial_transmit_flag;
        logic counter_array_overflow_flag;
        logic [CA_MODULES-1:0] counter_module_match_flag;
    } irq_flags_t;

    // what the core sees
    typedef struct packed {
        logic req;
        logic [15:0] vector;
        logic [1:0] level;
    } core_req_t;

    // whole state of the unit
    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic aw_have;
        logic w_have;
        logic [ADDR_W-1:0] awaddr;
        logic [31:0] wdata;
        logic wstrb0;
        logic [7:0] enable;
        logic [6:0] prio_high;
        logic [6:0] prio_low;
        logic [NUM_LEVELS-1:0] in_service;
        core_req_t core;
    } irq_state_t;
endpackage
`default_nettype wire

/* File: logic/prioritized_vector_interrupt_unit.sv */
// prioritized vector interrupt unit with an axi4-lite register slave
//
// Chosen here: the AXI4-Lite slave port.
`default_nettype none
// Contract
// - reset vector zero, fixed vectors, polling order
// - combined serial, timer 2, counter requests
// - global enable bit 7 gates everything
// - bit 6 enables counter array interrupt
// - bit 5 enables timer 2 interrupt
// - bit 4 enables serial port interrupt
// - bit 3 enables timer 1 interrupt
// - bit 2 enables external 1 interrupt
// - bit 1 enables timer 0 interrupt
// - bit 0 enables external 0 interrupt
// - enable resets zero, bit access allowed
// - priority low bits 6..0 per source
// - priority high bits, 00 lowest, 11 highest
// - priority low clears, bit access allowed
// - priority high clears, byte access only
// - level is high bit then low bit
// - only higher level preempts a service
// - highest level first, ties by polling
module prioritized_vector_interrupt_unit (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address and data
    input wire logic [irq_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [irq_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // request flags from the peripherals
    input wire irq_pkg::irq_flags_t flags,
    // processor core side
    output irq_pkg::core_req_t core_req,
    input wire logic core_ack,
    input wire logic core_return
);
    import irq_pkg::*;

    irq_state_t s_q;
    irq_state_t s_d;

    // per-cycle helpers
    logic [NUM_SRC-1:0] raw_req;
    logic [NUM_SRC-1:0] pending;
    logic [1:0] lvl [0:NUM_SRC-1];
    logic [1:0] cur_level;
    logic best_found;
    logic [1:0] best_lvl;
    logic [2:0] best_src;
    logic [7:0] widx;
    logic [7:0] ridx;
    logic [2:0] bnum;
    logic [1:0] btgt;
    logic bval;
    logic wr_err;

    // combined requests per source
    always_comb begin
        raw_req = '0;
        raw_req[SRC_EXT0] = flags.ext0_request_flag;
        raw_req[SRC_TIMER0] = flags.timer0_overflow_flag;
        raw_req[SRC_EXT1] = flags.ext1_request_flag;
        raw_req[SRC_TIMER1] = flags.timer1_overflow_flag;
        raw_req[SRC_SERIAL] = flags.serial_receive_flag
            | flags.serial_transmit_flag;
        raw_req[SRC_TIMER2] = flags.timer2_overflow_flag
            | flags.timer2_external_flag;
        raw_req[SRC_COUNTER_ARRAY] = flags.counter_array_overflow_flag
            | (|flags.counter_module_match_flag);
    end

    // gating: each source bit of the enable register matches its bit
    // position, so one mask covers bits 0..6
    always_comb begin
        pending = raw_req & s_q.enable[NUM_SRC-1:0];
        if (!s_q.enable[GLOBAL_EN_BIT]) begin
            pending = '0;
        end
    end

    // level per source, high bit is the upper digit
    always_comb begin
        for (int i = 0; i < NUM_SRC; i++) begin
            lvl[i] = {s_q.prio_high[i], s_q.prio_low[i]};
        end
    end

    // highest level now in service
    always_comb begin
        cur_level = 2'h0;
        for (int l = 0; l < NUM_LEVELS; l++) begin
            if (s_q.in_service[l]) begin
                cur_level = 2'(l);
            end
        end
    end

    // arbitration: levels from the top, then the polling order
    always_comb begin
        best_found = 1'b0;
        best_lvl = 2'h0;
        best_src = 3'h0;
        for (int l = NUM_LEVELS - 1; l >= 0; l--) begin
            for (int p = 0; p < NUM_SRC; p++) begin
                if (!best_found && pending[POLL_ORDER[p]]
                        && lvl[POLL_ORDER[p]] == 2'(l)) begin
                    best_found = 1'b1;
                    best_lvl = 2'(l);
                    best_src = 3'(POLL_ORDER[p]);
                end
            end
        end
    end

    // address decode of captured write and incoming read
    always_comb begin
        widx = s_q.awaddr[ADDR_W-1:2];
        ridx = s_axi_araddr[ADDR_W-1:2];
        bnum = s_q.wdata[BITOP_NUM_LSB +: 3];
        btgt = s_q.wdata[BITOP_TGT_LSB +: 2];
        bval = s_q.wdata[BITOP_VAL_BIT];
    end

    // next state
    always_comb begin
        s_d = s_q;
        wr_err = 1'b0;

        // write channels are taken in either order and held
        if (s_axi_awvalid && s_q.awready) begin
            s_d.awaddr = s_axi_awaddr;
            s_d.aw_have = 1'b1;
            s_d.awready = 1'b0;
        end
        if (s_axi_wvalid && s_q.wready) begin
            s_d.wdata = s_axi_wdata;
            s_d.wstrb0 = s_axi_wstrb[0];
            s_d.w_have = 1'b1;
            s_d.wready = 1'b0;
        end

        // both halves held: perform the write, raise the response
        if (s_q.aw_have && s_q.w_have && !s_q.bvalid) begin
            // only the low byte lane carries register data
            case (widx)
                IDX_ENABLE: begin
                    if (s_q.wstrb0) begin
                        s_d.enable = s_q.wdata[7:0];
                    end
                end
                IDX_PRIO_HIGH: begin
                    if (s_q.wstrb0) begin
                        s_d.prio_high = s_q.wdata[6:0];
                    end
                end
                IDX_PRIO_LOW: begin
                    if (s_q.wstrb0) begin
                        s_d.prio_low = s_q.wdata[6:0];
                    end
                end
                IDX_BIT_OP: begin
                    // single-bit set or clear; priority high refuses it
                    if (btgt == TGT_ENABLE) begin
                        s_d.enable[bnum] = bval;
                    end else if (btgt == TGT_PRIO_LOW && bnum != 3'h7) begin
                        s_d.prio_low[bnum] = bval;
                    end else begin
                        wr_err = 1'b1;
                    end
                end
                IDX_STATUS: begin
                    wr_err = 1'b1;
                end
                default: begin
                    wr_err = 1'b1;
                end
            endcase
            s_d.bvalid = 1'b1;
            s_d.bresp = wr_err ? RESP_SLVERR : RESP_OKAY;
        end

        // response taken: release both channels for the next write
        if (s_q.bvalid && s_axi_bready) begin
            s_d.bvalid = 1'b0;
            s_d.aw_have = 1'b0;
            s_d.w_have = 1'b0;
            s_d.awready = 1'b1;
            s_d.wready = 1'b1;
        end

        // read: one outstanding, data registered one edge after address
        if (s_axi_arvalid && s_q.arready) begin
            s_d.arready = 1'b0;
            s_d.rvalid = 1'b1;
            s_d.rresp = RESP_OKAY;
            s_d.rdata = '0;
            case (ridx)
                IDX_ENABLE: begin
                    s_d.rdata[7:0] = s_q.enable;
                end
                IDX_PRIO_HIGH: begin
                    s_d.rdata[6:0] = s_q.prio_high; // bit 7 reads zero
                end
                IDX_PRIO_LOW: begin
                    s_d.rdata[6:0] = s_q.prio_low;
                end
                IDX_BIT_OP: begin
                    s_d.rdata = '0;
                end
                IDX_STATUS: begin
                    s_d.rdata[STAT_ISV_LSB +: NUM_LEVELS] = s_q.in_service;
                    s_d.rdata[STAT_LVL_LSB +: 2] = s_q.core.level;
                    s_d.rdata[STAT_REQ_BIT] = s_q.core.req;
                    s_d.rdata[STAT_PEND_LSB +: NUM_SRC] = pending;
                end
                default: begin
                    s_d.rresp = RESP_SLVERR;
                end
            endcase
        end
        if (s_q.rvalid && s_axi_rready) begin
            s_d.rvalid = 1'b0;
            s_d.arready = 1'b1;
        end

        // service bookkeeping: a return closes the top level first,
        // then an ack opens the level it was presented at
        if (core_return) begin
            s_d.in_service[cur_level] = 1'b0;
        end
        if (core_ack && s_q.core.req) begin
            s_d.in_service[s_q.core.level] = 1'b1;
        end

        // present the winner only if it outranks the running service;
        // ack drops the request for one edge so it is not taken twice
        s_d.core.req = best_found && !(core_ack && s_q.core.req)
            && (s_q.in_service == '0 || best_lvl > cur_level);
        s_d.core.level = best_lvl;
        s_d.core.vector = best_found ? SRC_VECTOR[best_src]
            : RESET_VECTOR;
    end

    // single state register, synchronous reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q <= '0;
            s_q.awready <= 1'b1;
            s_q.wready <= 1'b1;
            s_q.arready <= 1'b1;
            s_q.enable <= ENABLE_RESET;
            s_q.prio_high <= PRIO_RESET;
            s_q.prio_low <= PRIO_RESET;
            s_q.core.vector <= RESET_VECTOR;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs straight from the state register
    assign s_axi_awready = s_q.awready;
    assign s_axi_wready = s_q.wready;
    assign s_axi_bvalid = s_q.bvalid;
    assign s_axi_bresp = s_q.bresp;
    assign s_axi_arready = s_q.arready;
    assign s_axi_rvalid = s_q.rvalid;
    assign s_axi_rresp = s_q.rresp;
    assign s_axi_rdata = s_q.rdata;
    assign core_req = s_q.core;
endmodule
`default_nettype wire

/* File: tb/irq_core_model.sv */
// processor core stand-in: takes requests and ends services
`default_nettype none
module irq_core_model (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // bench controls
    input wire logic take_en,
    input wire logic end_pulse,
    // interrupt unit side
    input wire irq_pkg::core_req_t core_req,
    output logic core_ack,
    output logic core_return
);
    // one-cycle take; the !core_ack term keeps it a pulse
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            core_ack <= 1'b0;
            core_return <= 1'b0;
        end else begin
            core_ack <= take_en && core_req.req && !core_ack;
            core_return <= end_pulse;
        end
    end
endmodule
`default_nettype wire

/* File: tb/irq_unit_checker.sv */
// port assertions of the interrupt unit
`default_nettype none
module irq_unit_checker
    import irq_pkg::*;
(
    // clock and reset
    input wire logic aclk, aresetn,
    // register bus
    input wire logic s_axi_awvalid, s_axi_awready, s_axi_wvalid,
    input wire logic s_axi_wready, s_axi_bvalid, s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid, s_axi_arready, s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    // sources and core
    input wire irq_pkg::irq_flags_t flags,
    input wire irq_pkg::core_req_t core_req,
    input wire logic core_ack
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // a presented request always carries one of the fixed vectors
    AST_VEC_SET: assert property (
        core_req.req |-> core_req.vector inside {SRC_VECTOR})
        else $error("request vector outside the table");
    AST_FLAG_CAUSE: assert property (
        core_req.req |-> $past(|flags))
        else $error("request without any flag");
    AST_EXT0: assert property (
        core_req.req && core_req.vector == 16'h0003
        |-> $past(flags.ext0_request_flag))
        else $error("external 0 vector without its flag");
    AST_SERIAL: assert property (
        core_req.req && core_req.vector == 16'h0023 |->
        $past(flags.serial_receive_flag || flags.serial_transmit_flag))
        else $error("serial vector without its flags");
    AST_CA: assert property (
        core_req.req && core_req.vector == 16'h0033 |->
        $past(flags.counter_array_overflow_flag
        || |flags.counter_module_match_flag))
        else $error("counter array vector without its flags");
    // a taken request leaves the core side for one edge
    AST_ACK_TAKE: assert property (
        core_ack && core_req.req |=> !core_req.req)
        else $error("request stayed after the take");
    AST_B_HOLD: assert property (
        s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    AST_R_HOLD: assert property (
        s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    AST_W_LAT: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##2 s_axi_bvalid)
        else $error("write response late");
    cover property (core_ack && core_req.req);
    cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
    cover property (core_req.req && core_req.level == 2'h3);
endmodule
bind prioritized_vector_interrupt_unit irq_unit_checker u_chk (
    .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
    .s_axi_rdata, .flags, .core_req, .core_ack);
`default_nettype wire

/* File: tb/tb_prioritized_vector_interrupt_unit.sv */
// self-checking bench of the prioritized vector interrupt unit
`default_nettype none
module tb_prioritized_vector_interrupt_unit;
    timeunit 1ns;
    timeprecision 1ps;
    import irq_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = '0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    irq_flags_t flags = '0;
    core_req_t core_req;
    logic core_ack, core_return;
    logic take_en = 1'b0, end_pulse = 1'b0;
    int err_count = 0, checks = 0;

    prioritized_vector_interrupt_unit u_dut (.aclk, .aresetn,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .flags, .core_req, .core_ack, .core_return);
    irq_core_model u_core (.aclk, .aresetn, .take_en, .end_pulse,
        .core_req, .core_ack, .core_return);

    // 100 MHz clock
    initial begin
        forever #5 aclk = ~aclk;
    end

    task automatic print_verdict();
        if (err_count == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // write; each channel released at the edge that takes it
    task automatic wr(input logic [7:0] idx, input logic [7:0] d,
            input logic [1:0] er);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_awaddr <= {idx, 2'b00};
        s_axi_wdata <= {24'h00_0000, d};
        s_axi_wstrb <= 4'hf;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid && n < 40);
        s_axi_bready <= 1'b0;
        check(32'(s_axi_bresp), 32'(er));
        if (n >= 40) begin
            err_count++;
            print_verdict();
        end
    endtask

    task automatic rd(input logic [7:0] idx, input logic [31:0] ed,
            input logic [1:0] er);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_araddr <= {idx, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid && n < 40);
        s_axi_rready <= 1'b0;
        check(s_axi_rdata, ed);
        check(32'(s_axi_rresp), 32'(er));
        if (n >= 40) begin
            err_count++;
            print_verdict();
        end
    endtask

    // flags reach the core side one edge later; three edges is margin
    task automatic look(input logic rq, input logic [15:0] v,
            input logic [1:0] lv);
        repeat (3) @(posedge aclk);
        check(32'({core_req.req, core_req.vector}), 32'({rq, v}));
        if (rq) check(32'(core_req.level), 32'(lv));
    endtask

    // alt picks which half of a combined source raises it
    function automatic irq_flags_t flags_of(input logic [6:0] m,
            input logic alt);
        irq_flags_t f;
        f = '0;
        f.ext0_request_flag = m[SRC_EXT0];
        f.timer0_overflow_flag = m[SRC_TIMER0];
        f.ext1_request_flag = m[SRC_EXT1];
        f.timer1_overflow_flag = m[SRC_TIMER1];
        f.serial_receive_flag = m[SRC_SERIAL] & alt;
        f.serial_transmit_flag = m[SRC_SERIAL] & !alt;
        f.timer2_overflow_flag = m[SRC_TIMER2] & alt;
        f.timer2_external_flag = m[SRC_TIMER2] & !alt;
        f.counter_array_overflow_flag = m[SRC_COUNTER_ARRAY] & alt;
        f.counter_module_match_flag = {m[SRC_COUNTER_ARRAY] & !alt, 4'h0};
        return f;
    endfunction

    initial begin
        logic [6:0] m;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        rd(IDX_ENABLE, 32'h0000_0000, RESP_OKAY);
        rd(IDX_PRIO_LOW, 32'h0000_0000, RESP_OKAY);
        rd(IDX_PRIO_HIGH, 32'h0000_0000, RESP_OKAY);
        rd(8'h10, 32'h0000_0000, RESP_SLVERR);
        // each source alone: own bit, global gate, own mask
        for (int s = 0; s < NUM_SRC; s++) begin
            flags <= flags_of(7'h01 << s, s[0]);
            wr(IDX_ENABLE, 8'h80 | (8'h01 << s), RESP_OKAY);
            look(1'b1, SRC_VECTOR[s], 2'h0);
            wr(IDX_ENABLE, 8'h7f, RESP_OKAY);
            look(1'b0, 16'h0000, 2'h0);
            wr(IDX_ENABLE, ~(8'h01 << s), RESP_OKAY);
            look(1'b0, 16'h0000, 2'h0);
        end
        // single-bit access: enable yes, reserved and priority-high no;
        // software only ever puts zero into reserved bit 7
        wr(IDX_ENABLE, 8'h00, RESP_OKAY);
        wr(IDX_BIT_OP, 8'h87, RESP_OKAY);
        rd(IDX_ENABLE, 32'h0000_0080, RESP_OKAY);
        wr(IDX_BIT_OP, 8'h0f, RESP_SLVERR);
        wr(IDX_BIT_OP, 8'h96, RESP_SLVERR);
        // all pending at one level: winners follow the polling order
        wr(IDX_ENABLE, 8'hff, RESP_OKAY);
        m = 7'h7f;
        for (int i = 0; i < NUM_SRC; i++) begin
            flags <= flags_of(m, 1'b0);
            look(1'b1, SRC_VECTOR[POLL_ORDER[i]], 2'h0);
            m[POLL_ORDER[i]] = 1'b0;
        end
        // levels from the high and low bits
        flags <= flags_of(7'h7f, 1'b1);
        wr(IDX_PRIO_LOW, 8'h10, RESP_OKAY);
        look(1'b1, 16'h0023, 2'h1);
        wr(IDX_PRIO_HIGH, 8'h20, RESP_OKAY);
        look(1'b1, 16'h002b, 2'h2);
        wr(IDX_BIT_OP, 8'h8e, RESP_OKAY);
        look(1'b1, 16'h002b, 2'h2);
        wr(IDX_PRIO_HIGH, 8'h60, RESP_OKAY);
        look(1'b1, 16'h0033, 2'h3);
        rd(IDX_PRIO_LOW, 32'h0000_0050, RESP_OKAY);
        rd(IDX_PRIO_HIGH, 32'h0000_0060, RESP_OKAY);
        // level 0 in service; level 1 preempts, level 0 cannot;
        // a held-back winner still shows its vector, req stays low
        flags <= flags_of(7'h01, 1'b1);
        take_en <= 1'b1;
        repeat (4) @(posedge aclk);
        take_en <= 1'b0;
        look(1'b0, 16'h0003, 2'h0);
        flags <= flags_of(7'h11, 1'b1);
        look(1'b1, 16'h0023, 2'h1);
        take_en <= 1'b1;
        repeat (4) @(posedge aclk);
        take_en <= 1'b0;
        flags <= flags_of(7'h19, 1'b1);
        look(1'b0, 16'h0023, 2'h0);
        // status: levels 0 and 1 in service, level 1 shown, 3 pending
        rd(IDX_STATUS, 32'h0000_1913, RESP_OKAY);
        wr(IDX_STATUS, 8'h00, RESP_SLVERR);
        // end of the level 1 service lets serial in again
        end_pulse <= 1'b1;
        @(posedge aclk);
        end_pulse <= 1'b0;
        look(1'b1, 16'h0023, 2'h1);
        flags <= flags_of(7'h7f, 1'b1);
        look(1'b1, 16'h0033, 2'h3);
        print_verdict();
    end
endmodule
`default_nettype wire
